// file: bench/dsw_host.sv
// Host serial port model: frames words MSB first and gathers the serial output.
`timescale 1ns/1ps
module dsw_host (
	output dsw_pkg::dsw_link_t link,
	input wire logic sdo
);
	// Clock stands still low and frame high between frames
	initial link = 3'b100;
	// Data moves on rising clock so it is steady at the falling sample
	task automatic send(input logic [23:0] w, input int nbits, output logic [23:0] rd);
		rd = 24'h000000;
		link.frame_n = 1'b0;
		#50;
		for (int i = nbits - 1; i >= 0; i--) begin
			link.sclk = 1'b1;
			link.din = w[i % 24];
			#100 link.sclk = 1'b0;
			#100 rd = {rd[22:0], sdo};
		end
		link.frame_n = 1'b1;
		link.din = ~link.din; // Released line keeps no stale bit
		#100;
	endtask
endmodule

// file: bench/dsw_monitor.sv
// Concurrent checks on the DAC serial write port outputs.
`timescale 1ns/1ps
module dsw_monitor #(
	parameter int CHANNELS = 16,
	parameter int BUSY_CYC = 26,
	parameter int RESP_CYC = 4,
	parameter int CLR_CYC = 480
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire dsw_pkg::dsw_link_t link,
	input wire logic load_outputs_n,
	input wire logic clear_n,
	input wire logic daisy_mode,
	input wire logic auto_update,
	input wire logic sdo_oe,
	input wire logic busy_n,
	input wire logic [CHANNELS*16-1:0] dac_out,
	input wire logic clear_done
);
	localparam int CLR_LIM = CLR_CYC;
	logic [5:0] bc_reg, ba_reg, la_reg;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Length of the current busy run
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) bc_reg <= 6'h00;
		else bc_reg <= busy_n ? 6'h00 : bc_reg + 6'h01;
	end
	// Ages since busy and load were low; saturate so long idles never wrap
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) ba_reg <= 6'h3F;
		else ba_reg <= !busy_n ? 6'h00 : ba_reg + {5'h00, ba_reg != 6'h3F};
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) la_reg <= 6'h3F;
		else la_reg <= !load_outputs_n ? 6'h00 : la_reg + {5'h00, la_reg != 6'h3F};
	end
	sequence s_low; !busy_n[*8]; endsequence
	sequence s_quiet; (!daisy_mode && link.frame_n)[*4]; endsequence
	sequence s_chain; (daisy_mode && !link.frame_n)[*4]; endsequence
	a_busy_exact: assert property ($rose(busy_n) |-> bc_reg == BUSY_CYC)
		else $error("busy low width wrong");
	a_busy_max: assert property (!busy_n |-> bc_reg < BUSY_CYC)
		else $error("busy held too long");
	a_busy_run: assert property ($fell(busy_n) |-> s_low)
		else $error("busy pulse cut short");
	a_auto_resp: assert property ($changed(dac_out) && auto_update && !clear_done |-> ba_reg <= RESP_CYC)
		else $error("auto update late or unprompted");
	a_load_resp: assert property ($changed(dac_out) && !auto_update && !clear_done |-> la_reg < 8)
		else $error("output moved without load");
	a_clear_bound: assert property ($rose(clear_n) |-> ##[1:CLR_LIM] clear_done)
		else $error("clear not completed");
	a_clear_zero: assert property (clear_done |-> dac_out == '0)
		else $error("clear left outputs set");
	a_sdo_quiet: assert property (s_quiet |-> !sdo_oe)
		else $error("serial out driven idle");
	a_sdo_chain: assert property (s_chain |-> sdo_oe)
		else $error("serial out not driven in chain");
endmodule
bind dsw_port dsw_monitor #(.CHANNELS(CHANNELS), .BUSY_CYC(BUSY_CYC), .RESP_CYC(RESP_CYC), .CLR_CYC(CLR_CYC)) u_mon (
	.core_clk(core_clk), .reset_n(reset_n), .link(link), .load_outputs_n(load_outputs_n),
	.clear_n(clear_n), .daisy_mode(daisy_mode), .auto_update(auto_update), .sdo_oe(sdo_oe),
	.busy_n(busy_n), .dac_out(dac_out), .clear_done(clear_done));

// file: bench/tb.sv
// Testbench for the DAC serial write port: writes, load, clear, readback, daisy chain.
`timescale 1ns/1ps
module tb;
	localparam int CLR = 40;
	logic core_clk = 0, reset_n = 0, load_outputs_n = 1, clear_n = 1;
	logic daisy_mode = 0, auto_update = 1;
	logic sdo, sdo_oe, busy_n, boost, clear_done;
	logic [255:0] dac_out, snap;
	logic [23:0] rd;
	dsw_pkg::dsw_link_t link;
	int miscompares = 0, tests_run = 0;
	dsw_host host (.link(link), .sdo(sdo));
	dsw_port #(.CLR_CYC(CLR)) dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
		.link(link), .load_outputs_n(load_outputs_n), .clear_n(clear_n), .daisy_mode(daisy_mode),
		.auto_update(auto_update), .sdo(sdo), .sdo_oe(sdo_oe), .busy_n(busy_n), .dac_out(dac_out),
		.boost(boost), .clear_done(clear_done));
	// 40 MHz core clock
	initial forever #12.5 core_clk = ~core_clk;
	task automatic check(input string name, input logic [255:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	// Bounded wait for busy to end, then room for the output update
	task automatic settle;
		cyc(2);
		for (int i = 0; i < 100 && busy_n !== 1'b1; i++) cyc(1);
		check("busy end", busy_n, 1'b1);
		cyc(8);
	endtask
	task automatic pulse_load;
		load_outputs_n = 1'b0;
		cyc(2);
		load_outputs_n = 1'b1;
	endtask
	task automatic t_auto;
		host.send({1'b0, 7'h03, 16'hA5C3}, 24, rd);
		settle();
		check("ch3", dac_out[48+:16], 16'hA5C3);
		check("ch4", dac_out[64+:16], 16'h0000);
	endtask
	// Load during busy is refused; after busy it copies
	task automatic t_load;
		auto_update = 1'b0;
		host.send({1'b0, 7'h05, 16'h1234}, 24, rd);
		pulse_load();
		settle();
		check("ch5 early", dac_out[80+:16], 16'h0000);
		pulse_load();
		cyc(8);
		check("ch5 load", dac_out[80+:16], 16'h1234);
		auto_update = 1'b1;
	endtask
	task automatic t_boost;
		host.send({1'b0, 7'h0C, 16'h0001}, 24, rd);
		settle();
		check("boost", boost, 1'b1);
		snap = dac_out;
		host.send({1'b0, 7'h40, 16'hFFFF}, 24, rd);
		settle();
		check("unmapped", dac_out, snap);
	endtask
	task automatic t_readback;
		host.send({1'b1, 7'h03, 16'h0000}, 24, rd);
		settle();
		host.send({1'b0, 7'h7F, 16'h0000}, 24, rd);
		settle();
		check("readback", rd, 24'h00A5C3);
	endtask
	// Longer frame: the last 24 bits count, then come back out
	task automatic t_daisy;
		daisy_mode = 1'b1;
		host.send({1'b0, 7'h02, 16'h5A5A}, 26, rd);
		settle();
		check("ch2", dac_out[32+:16], 16'h5A5A);
		host.send({1'b0, 7'h7F, 16'h0000}, 24, rd);
		settle();
		check("chain out", rd, {1'b0, 7'h02, 16'h5A5A});
		daisy_mode = 1'b0;
	endtask
	task automatic t_clear;
		clear_n = 1'b0;
		cyc(2);
		clear_n = 1'b1;
		for (int i = 0; i < CLR + 20 && clear_done !== 1'b1; i++) cyc(1);
		check("clear done", clear_done, 1'b1);
		check("cleared", dac_out, '0);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Watchdog well beyond the expected run of about 50 us
	initial begin
		#2000000;
		miscompares++;
		final_report();
	end
	initial begin
		cyc(20);
		reset_n = 1'b1;
		cyc(5);
		t_auto();
		t_load();
		t_boost();
		t_readback();
		t_daisy();
		t_clear();
		final_report();
	end
endmodule

// file: pkg/dsw_defs.svh
// Constants for the DAC serial write port: timing counts, widths, field positions.
`ifndef DSW_DEFS_SVH
`define DSW_DEFS_SVH
`define DSW_CLK_NS 25
`define DSW_WORD_BITS 24
`define DSW_BUSY_FALL_NS 30
`define DSW_BUSY_FALL_CYC ((`DSW_BUSY_FALL_NS) / (`DSW_CLK_NS))
`define DSW_BUSY_LOW_NS 670
`define DSW_BUSY_LOW_CYC ((`DSW_BUSY_LOW_NS) / (`DSW_CLK_NS))
`define DSW_OUT_RESP_NS 100
`define DSW_OUT_RESP_CYC ((`DSW_OUT_RESP_NS) / (`DSW_CLK_NS))
`define DSW_CLR_PULSE_NS 20
`define DSW_CLR_PULSE_CYC (((`DSW_CLR_PULSE_NS) + (`DSW_CLK_NS) - 1) / (`DSW_CLK_NS))
`define DSW_CLR_ACT_NS 12000
`define DSW_CLR_ACT_CYC ((`DSW_CLR_ACT_NS) / (`DSW_CLK_NS))
`define DSW_RW_BIT 23
`define DSW_ADDR_MSB 22
`define DSW_ADDR_LSB 16
`define DSW_DATA_MSB 15
`define DSW_DATA_LSB 0
`define DSW_NOP_ADDR 7'h7F
`define DSW_CTRL_ADDR 7'h0C
`define DSW_BOOST_BIT 0
`define DSW_CLEAR_CODE 16'h0000
`define DSW_CTRL_RESET 16'h0000
`endif

// file: pkg/dsw_pkg.sv
// Types shared by the DAC serial write port.
package dsw_pkg;
	typedef struct packed {
		logic frame_n;
		logic sclk;
		logic din;
	} dsw_link_t;
	typedef struct packed {
		logic readback;
		logic [6:0] addr;
		logic [15:0] data;
	} dsw_word_t;
	typedef enum logic [1:0] {
		DSW_IDLE,
		DSW_WAIT,
		DSW_BUSY
	} dsw_state_t;
endpackage

// file: verilog/dsw_port.sv
// Serial write port of a multichannel voltage-output DAC, with readback and daisy chain.
`timescale 1ns/1ps
`include "dsw_defs.svh"
// Summary of operation
// - A standalone write frame is 24 bits and the 24th falling serial clock edge completes the input word; in daisy chain frame rising does.
// - Busy goes low 50 to 75 ns after the edge that completes the word, behind the pin synchroniser, and stays low no more than 670 ns.
// - With automatic update the new output value is driven within 100 ns of busy rising.
// - Load strobe may fall no earlier than busy rising, is held 20 ns, and its falling edge updates outputs.
// - Clear is held low 20 ns and the outputs are cleared within 12 us.
// - In daisy-chain mode data leaves on the serial output, changing after rising clock edges.
// - A readback word names a register, and its contents are shifted out during the following frame.
// - A boost bit in the control register selects the amplifier slew rate.
module dsw_port #(
	parameter int CHANNELS = 16,
	parameter int BUSY_CYC = `DSW_BUSY_LOW_CYC,
	parameter int RESP_CYC = `DSW_OUT_RESP_CYC,
	parameter int CLR_CYC = `DSW_CLR_ACT_CYC
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire dsw_pkg::dsw_link_t link,
	input wire logic load_outputs_n,
	input wire logic clear_n,
	input wire logic daisy_mode,
	input wire logic auto_update,
	output logic sdo,
	output logic sdo_oe,
	output logic busy_n,
	output logic [CHANNELS*16-1:0] dac_out,
	output logic boost,
	output logic clear_done
);
	localparam int CW = $clog2(CHANNELS);
	initial begin
		// One channel would leave the index slice without bits
		if (CHANNELS < 2 || CHANNELS > 64) $error("CHANNELS out of range");
		if (BUSY_CYC < 2 || BUSY_CYC > 1024 || RESP_CYC < 1 || RESP_CYC > 8) $error("bad timing count");
		if (CLR_CYC < 4 || CLR_CYC > 65535) $error("bad clear count");
	end
	logic rst_meta_reg, rst_n;
	logic [4:0] pin_s;
	logic frame_n_s, sclk_s, din_s, load_n_s, clr_n_s;
	logic sclk_d_reg, frame_d_reg, load_d_reg;
	logic sclk_fall, sclk_rise, frame_rise, frame_fall, load_fall;
	logic [23:0] shift_reg;
	logic [4:0] count_reg;
	logic [23:0] out_reg;
	dsw_pkg::dsw_word_t word;
	logic accept;
	dsw_pkg::dsw_state_t state_reg;
	logic [9:0] busy_cnt_reg;
	logic [2:0] resp_cnt_reg;
	logic commit_pend_reg;
	logic [15:0] input_reg [CHANNELS];
	logic [15:0] ctrl_reg;
	logic [6:0] pend_addr_reg;
	logic pend_read_reg;
	logic [15:0] clr_cnt_reg;
	logic [5:0] clr_low_reg;

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// Pins come from the host's domain, so each passes two flops
	dsw_sync #(.WIDTH(5)) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(clk_en),
		.async_in({link.frame_n, link.sclk, link.din, load_outputs_n, clear_n}),
		.reset_val(5'h1F),
		.sync_out(pin_s)
	);
	assign {frame_n_s, sclk_s, din_s, load_n_s, clr_n_s} = pin_s;

	// Edge detectors on the synchronised copies
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_d_reg <= 1'b1;
			frame_d_reg <= 1'b1;
			load_d_reg <= 1'b1;
		end else if (clk_en) begin
			sclk_d_reg <= sclk_s;
			frame_d_reg <= frame_n_s;
			load_d_reg <= load_n_s;
		end
	end
	assign sclk_fall = sclk_d_reg & ~sclk_s;
	assign sclk_rise = ~sclk_d_reg & sclk_s;
	assign frame_rise = ~frame_d_reg & frame_n_s;
	assign frame_fall = frame_d_reg & ~frame_n_s;
	assign load_fall = load_d_reg & ~load_n_s;

	// Shift in on falling edges while framed; count restarts each frame
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_reg <= 24'h000000;
			count_reg <= 5'h00;
		end else if (clk_en) begin
			if (frame_fall) begin
				count_reg <= 5'h00;
			end else if (!frame_n_s && sclk_fall) begin
				shift_reg <= {shift_reg[22:0], din_s};
				if (count_reg != 5'h1F) begin
					count_reg <= count_reg + 5'h01;
				end
			end
		end
	end

	// Standalone takes the 24th edge; daisy chain waits for frame to rise
	always_comb begin
		if (daisy_mode) begin
			accept = frame_rise && count_reg >= 5'(`DSW_WORD_BITS);
		end else begin
			accept = !frame_n_s && sclk_fall && count_reg == 5'(`DSW_WORD_BITS - 1);
		end
	end
	assign word = daisy_mode ? shift_reg : {shift_reg[22:0], din_s};

	// Busy sequence: low in the cycle after accept, well inside 30 ns of the edge as seen here
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= dsw_pkg::DSW_IDLE;
			busy_cnt_reg <= 10'h000;
		end else if (clk_en) begin
			unique case (state_reg)
				dsw_pkg::DSW_IDLE: begin
					if (accept) begin
						state_reg <= dsw_pkg::DSW_BUSY;
						busy_cnt_reg <= 10'(BUSY_CYC - 1);
					end
				end
				dsw_pkg::DSW_BUSY: begin
					if (busy_cnt_reg == 10'h000) begin
						state_reg <= dsw_pkg::DSW_WAIT;
					end else begin
						busy_cnt_reg <= busy_cnt_reg - 10'h001;
					end
				end
				dsw_pkg::DSW_WAIT: begin
					state_reg <= accept ? dsw_pkg::DSW_BUSY : dsw_pkg::DSW_IDLE;
					busy_cnt_reg <= 10'(BUSY_CYC - 1);
				end
			endcase
		end
	end
	assign busy_n = (state_reg != dsw_pkg::DSW_BUSY);

	// Decode the accepted word into input or control registers, or a readback request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				input_reg[i] <= 16'h0000;
			end
			ctrl_reg <= `DSW_CTRL_RESET;
			pend_addr_reg <= 7'h00;
			pend_read_reg <= 1'b0;
		end else if (clk_en) begin
			if (accept) begin
				pend_read_reg <= word.readback;
				pend_addr_reg <= word.addr;
				if (!word.readback) begin
					if (word.addr == `DSW_CTRL_ADDR) begin
						ctrl_reg <= word.data;
					end else if (word.addr < 7'(CHANNELS)) begin
						input_reg[word.addr[CW-1:0]] <= word.data;
					end
				end
			end
		end
	end
	assign boost = ctrl_reg[`DSW_BOOST_BIT];

	// Automatic update counts from the edge that ends busy, so the output moves within RESP_CYC cycles of it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			commit_pend_reg <= 1'b0;
			resp_cnt_reg <= 3'h0;
		end else if (clk_en) begin
			if (state_reg == dsw_pkg::DSW_BUSY && busy_cnt_reg == 10'h000 && auto_update) begin
				commit_pend_reg <= 1'b1;
				resp_cnt_reg <= 3'(RESP_CYC - 1);
			end else if (commit_pend_reg) begin
				if (resp_cnt_reg == 3'h0) begin
					commit_pend_reg <= 1'b0;
				end else begin
					resp_cnt_reg <= resp_cnt_reg - 3'h1;
				end
			end
		end
	end

	// Clear pulse is measured and then applied after the activation delay
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_low_reg <= 6'h00;
			clr_cnt_reg <= 16'h0000;
			clear_done <= 1'b0;
		end else if (clk_en) begin
			clear_done <= 1'b0;
			if (!clr_n_s) begin
				if (clr_low_reg != 6'h3F) begin
					clr_low_reg <= clr_low_reg + 6'h01;
				end
			end else begin
				clr_low_reg <= 6'h00;
			end
			// The pulse minimum rounds up to one cycle, so any low seen in one sample counts as a pulse
			// Three cycles of synchroniser and load are taken off, so the span from the pin fits the limit
			if (clr_n_s && clr_low_reg >= 6'(`DSW_CLR_PULSE_CYC)) begin
				clr_cnt_reg <= 16'(CLR_CYC - 3);
			end else if (clr_cnt_reg != 16'h0000) begin
				clr_cnt_reg <= clr_cnt_reg - 16'h0001;
				clear_done <= (clr_cnt_reg == 16'h0001);
			end
		end
	end

	// Output latches; clear beats a simultaneous update
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dac_out <= '0;
		end else if (clk_en) begin
			if (clr_cnt_reg == 16'h0001) begin
				for (int i = 0; i < CHANNELS; i++) begin
					dac_out[i*16 +: 16] <= `DSW_CLEAR_CODE;
				end
			end else if ((commit_pend_reg && resp_cnt_reg == 3'h0) || (load_fall && busy_n)) begin
				for (int i = 0; i < CHANNELS; i++) begin
					dac_out[i*16 +: 16] <= input_reg[i];
				end
			end
		end
	end

	// Serial out: chain echo or readback data, changed after rising edges
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_reg <= 24'h000000;
			sdo <= 1'b0;
		end else if (clk_en) begin
			if (frame_fall && pend_read_reg) begin
				if (pend_addr_reg == `DSW_CTRL_ADDR) begin
					out_reg <= {8'h00, ctrl_reg};
				end else if (pend_addr_reg < 7'(CHANNELS)) begin
					out_reg <= {8'h00, input_reg[pend_addr_reg[CW-1:0]]};
				end else begin
					out_reg <= 24'h000000;
				end
			end else if (!frame_n_s && sclk_rise) begin
				sdo <= pend_read_reg ? out_reg[23] : shift_reg[23];
				out_reg <= {out_reg[22:0], 1'b0};
			end
		end
	end
	assign sdo_oe = (daisy_mode || pend_read_reg) && !frame_n_s;
endmodule

// file: verilog/dsw_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module dsw_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] reset_val,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	initial begin
		if (WIDTH < 1) $error("dsw_sync needs WIDTH >= 1");
	end
	// First stage feeds only the second; reset to high so idle pins look inactive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '1;
			sync_out <= '1;
		end else if (ce) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
